/* File: otp_sensor_end.sv */
// Purpose: Sensor-side sequencing of one-time range storage.
// Assumes: Host register writes arrive synchronous; the out pin is sampled twice.
// Notes:   Working registers sit at wr_addr 0..3; commands go to the command address.
`include "otp_defines.svh"

// Notes on behaviour
// - Pin range applied only after stop pulse.
// - Start pulse alone commits nothing.
// - Pin procedure accepted only once.
// - Pin procedure needs magnet detected.
// - Range register linear, 90 degrees is 0x400.
// - Host waits 1 ms after range writes.
// - Host waits 1 ms after settings commit.
// - Load sequence 01,11,10 reloads stored contents.
// - Host grounds option select for pin mode.
// - Low pulse of 100 ms latches position.
// - Host waits 1 ms after I2C zero write.
// - Failure holds pin low; success outputs position.
// - Command 0x40 commits range and settings.
// - Range commit only while commit count zero.
// - Command 0x80 commits positions, three times max.
module otp_sensor_end #(
  parameter int PULSE_CYC = `PULSE_MIN_CYC
) (
  input  wire logic  clk_in,
  input  wire logic  rst_in,
  input  wire logic  magnet_detected_in,
  input  wire logic [11:0] angle_in,
  output logic [11:0] position_out,
  otp_link_if.dev    link
);
  typedef enum logic [2:0] {PIN_IDLE, PIN_WAIT_STOP, PIN_BURN, PIN_DONE, PIN_FAIL} pin_state_t;
  pin_state_t  pin_state_r;
  logic [11:0] max_angle_range_r, settings_word_r, zero_position_r, stop_position_r;
  logic [11:0] nv_range_r, nv_settings_r, nv_zero_r, nv_stop_r;
  logic [1:0]  angle_commit_count_r;
  logic        settings_burnt_r;
  logic [1:0]  load_step_r;
  logic        pin_meta_r, pin_sync_r;
  logic [31:0] low_cnt_r;
  logic        pulse_seen_r;
  logic        pin_used_r;
  logic [11:0] pending_zero_r;
  logic        out_oe_r;
  logic        host_cmd;
  logic        pin_burn_ok;

  function automatic logic is_cmd(input logic [7:0] a, input logic [11:0] d, input logic [7:0] c);
    is_cmd = (a == `CMD_ADDR) && (d[7:0] == c);
  endfunction

  assign host_cmd = link.wr_valid && (link.wr_addr == `CMD_ADDR);
  assign pin_burn_ok = magnet_detected_in && !pin_used_r;

  always_ff @(posedge clk_in)
  begin
    pin_meta_r <= link.out_level;
    pin_sync_r <= pin_meta_r;
  end

  // Pulse timer counts low time; a release after the threshold yields one event.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      low_cnt_r    <= 32'h0;
      pulse_seen_r <= 1'b0;
    end
    else
    begin
      pulse_seen_r <= 1'b0;
      if (!pin_sync_r)
      begin
        if (low_cnt_r < PULSE_CYC)
          low_cnt_r <= low_cnt_r + 32'h1;
      end
      else
      begin
        pulse_seen_r <= (low_cnt_r >= PULSE_CYC);
        low_cnt_r    <= 32'h0;
      end
    end
  end

  // Working registers: host writes, position latches, reload of stored contents.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      max_angle_range_r <= 12'h000;
      settings_word_r   <= 12'h000;
      zero_position_r   <= 12'h000;
      stop_position_r   <= 12'h000;
    end
    else if (link.wr_valid && link.wr_addr < 8'h04)
    begin
      case (link.wr_addr[1:0])
        otp_pkg::REG_RANGE:    max_angle_range_r <= link.wr_data;
        otp_pkg::REG_SETTINGS: settings_word_r   <= link.wr_data;
        otp_pkg::REG_ZERO:     zero_position_r   <= link.wr_data;
        default:               stop_position_r   <= link.wr_data;
      endcase
    end
    else if (host_cmd && load_step_r == 2'h2 && is_cmd(link.wr_addr, link.wr_data, `CMD_LOAD_C))
    begin
      max_angle_range_r <= nv_range_r;
      settings_word_r   <= nv_settings_r;
      zero_position_r   <= nv_zero_r;
      stop_position_r   <= nv_stop_r;
    end
    else if (pulse_seen_r && pin_state_r == PIN_WAIT_STOP && pin_burn_ok)
    begin
      zero_position_r <= pending_zero_r;
      stop_position_r <= angle_in;
    end
  end

  // Reload sequence tracker: 0x01, 0x11, 0x10 back to back on the command address.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      load_step_r <= 2'h0;
    else if (host_cmd)
    begin
      if (is_cmd(link.wr_addr, link.wr_data, `CMD_LOAD_A))
        load_step_r <= 2'h1;
      else if (load_step_r == 2'h1 && is_cmd(link.wr_addr, link.wr_data, `CMD_LOAD_B))
        load_step_r <= 2'h2;
      else
        load_step_r <= 2'h0;
    end
  end

  // Stored contents and commit bookkeeping.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      nv_range_r           <= 12'h000;
      nv_settings_r        <= 12'h000;
      nv_zero_r            <= 12'h000;
      nv_stop_r            <= 12'h000;
      angle_commit_count_r <= `COMMIT_CNT_NONE;
      settings_burnt_r     <= 1'b0;
    end
    else if (host_cmd && is_cmd(link.wr_addr, link.wr_data, `CMD_BURN_SET) && !settings_burnt_r)
    begin
      settings_burnt_r <= 1'b1;
      nv_settings_r    <= settings_word_r;
      if (angle_commit_count_r == `COMMIT_CNT_NONE)
        nv_range_r <= max_angle_range_r;
    end
    else if (host_cmd && is_cmd(link.wr_addr, link.wr_data, `CMD_BURN_ANGLE)
             && magnet_detected_in && angle_commit_count_r != `MAX_ANGLE_COMMITS)
    begin
      nv_zero_r            <= zero_position_r;
      nv_stop_r            <= stop_position_r;
      angle_commit_count_r <= angle_commit_count_r + 2'h1;
    end
    else if (pin_state_r == PIN_BURN && angle_commit_count_r != `MAX_ANGLE_COMMITS)
    begin
      nv_zero_r            <= zero_position_r;
      nv_stop_r            <= stop_position_r;
      angle_commit_count_r <= angle_commit_count_r + 2'h1;
    end
  end

  // Pin procedure: start pulse, stop pulse, then commit or fail.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pin_state_r    <= PIN_IDLE;
      pin_used_r     <= 1'b0;
      pending_zero_r <= 12'h000;
    end
    else
    begin
      case (pin_state_r)
        PIN_IDLE:
          // The start position is held aside so the output keeps its old zero until the stop.
          if (pulse_seen_r && link.pgo_low && pin_burn_ok)
          begin
            pin_state_r    <= PIN_WAIT_STOP;
            pending_zero_r <= angle_in;
          end
        PIN_WAIT_STOP:
          if (pulse_seen_r)
            pin_state_r <= pin_burn_ok ? PIN_BURN : PIN_FAIL;
        PIN_BURN:
        begin
          pin_used_r  <= 1'b1;
          pin_state_r <= (angle_commit_count_r != `MAX_ANGLE_COMMITS) ? PIN_DONE : PIN_FAIL;
        end
        PIN_DONE:
          pin_state_r <= PIN_IDLE;
        PIN_FAIL:
          pin_state_r <= PIN_FAIL;
        default:
          pin_state_r <= PIN_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      out_oe_r     <= 1'b0;
      position_out <= 12'h000;
    end
    else
    begin
      out_oe_r     <= (pin_state_r == PIN_FAIL);
      position_out <= (pin_state_r == PIN_FAIL) ? 12'h000 : angle_in - zero_position_r;
    end
  end

  assign link.dev_out_oe      = out_oe_r;
  assign link.dev_out_o       = 1'b0;
  assign link.rd_range        = max_angle_range_r;
  assign link.rd_settings     = settings_word_r;
  assign link.rd_zero         = zero_position_r;
  assign link.rd_stop         = stop_position_r;
  assign link.rd_commit_count = angle_commit_count_r;
  assign link.rd_magnet       = magnet_detected_in;
endmodule

/* File: otp_defines.svh */
// Purpose: Shared constants for the one-time storage programming link.
// Assumes: 20 MHz clock on both ends.
// Notes:   Times are kept in their own unit and converted to cycles.
`ifndef OTP_DEFINES_SVH
`define OTP_DEFINES_SVH
`define CLK_HZ            20000000
`define CMD_ADDR          8'hFF
`define CMD_LOAD_A        8'h01
`define CMD_LOAD_B        8'h11
`define CMD_LOAD_C        8'h10
`define CMD_BURN_SET      8'h40
`define CMD_BURN_ANGLE    8'h80
`define RANGE_90_DEG      12'h400
`define PULSE_MIN_MS      100
`define PULSE_MIN_CYC     ((`PULSE_MIN_MS * `CLK_HZ + 999) / 1000)
`define WAIT_MIN_MS       1
`define WAIT_MIN_CYC      ((`WAIT_MIN_MS * `CLK_HZ + 999) / 1000)
`define MAX_ANGLE_COMMITS 2'h3
`define COMMIT_CNT_NONE   2'h0
`define BURN_CYC          16
`endif

/* File: otp_pkg.sv */
// Purpose: Types used by the sensor end of the programming link.
// Assumes: Nothing beyond the defines header.
// Notes:   Holds types only.
package otp_pkg;
  typedef enum logic [1:0] {REG_RANGE, REG_SETTINGS, REG_ZERO, REG_STOP} reg_sel_t;
endpackage

/* File: otp_link_if.sv */
// Purpose: Joins the sensor end with the controlling host end.
// Assumes: One clock; out pin is open drain with an internal pull-up.
// Notes:   The wire level is resolved here from both enables.
interface otp_link_if;
  logic        wr_valid;
  logic [7:0]  wr_addr;
  logic [11:0] wr_data;
  logic [11:0] rd_range;
  logic [11:0] rd_settings;
  logic [11:0] rd_zero;
  logic [11:0] rd_stop;
  logic [1:0]  rd_commit_count;
  logic        rd_magnet;
  logic        pgo_low;
  logic        dev_out_oe;
  logic        dev_out_o;
  logic        host_out_oe;
  logic        out_level;
  assign out_level = !((dev_out_oe && !dev_out_o) || host_out_oe);
  modport dev  (input wr_valid, wr_addr, wr_data, pgo_low, out_level,
                output rd_range, rd_settings, rd_zero, rd_stop, rd_commit_count,
                rd_magnet, dev_out_oe, dev_out_o);
  modport host (output wr_valid, wr_addr, wr_data, pgo_low, host_out_oe,
                input rd_range, rd_settings, rd_zero, rd_stop, rd_commit_count,
                rd_magnet, out_level);
endinterface

/* File: otp_host_end.sv */
// Purpose: Host sequencer issuing writes, commits, reloads and pin pulses.
// Assumes: One user command at a time; busy marks the guard wait.
// Notes:   Every operation is followed by the minimum wait; the three reload writes go back to back.
`include "otp_defines.svh"
module otp_host_end #(
  parameter int WAIT_CYC  = `WAIT_MIN_CYC,
  parameter int PULSE_CYC = `PULSE_MIN_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        req_in,
  input  wire logic [1:0]  op_in,
  input  wire logic [7:0]  addr_in,
  input  wire logic [11:0] data_in,
  input  wire logic        pin_mode_in,
  output logic             busy_out,
  output logic [11:0]      rd_range_out,
  output logic [11:0]      rd_settings_out,
  output logic             pin_fail_out,
  otp_link_if.host         link
);
  typedef enum logic [1:0] {H_IDLE, H_LOAD, H_PULSE, H_WAIT} host_state_t;
  host_state_t host_state_r;
  logic [31:0] cnt_r;
  logic [1:0]  load_idx_r;
  logic        wr_valid_r, pulse_r, pgo_r, meta_r, lvl_r;
  logic [7:0]  wr_addr_r;
  logic [11:0] wr_data_r;
  logic [1:0]  pulse_tail_r;

  always_ff @(posedge clk_in)
  begin
    meta_r <= link.out_level;
    lvl_r  <= meta_r;
  end

  // op 0: register or command write; 1: reload sequence; 2: pin pulse.
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      host_state_r <= H_IDLE;
      cnt_r        <= 32'h0;
      load_idx_r   <= 2'h0;
      wr_valid_r   <= 1'b0;
      wr_addr_r    <= 8'h00;
      wr_data_r    <= 12'h000;
      pulse_r      <= 1'b0;
      busy_out     <= 1'b0;
    end
    else
    begin
      wr_valid_r <= 1'b0;
      case (host_state_r)
        H_IDLE:
          if (req_in)
          begin
            busy_out <= 1'b1;
            cnt_r    <= 32'h0;
            if (op_in == 2'h1)
              host_state_r <= H_LOAD;
            else if (op_in == 2'h2)
            begin
              pulse_r      <= 1'b1;
              host_state_r <= H_PULSE;
            end
            else
            begin
              wr_valid_r   <= 1'b1;
              wr_addr_r    <= addr_in;
              wr_data_r    <= data_in;
              host_state_r <= H_WAIT;
            end
          end
        H_LOAD:
        begin
          wr_valid_r <= 1'b1;
          wr_addr_r  <= `CMD_ADDR;
          wr_data_r  <= (load_idx_r == 2'h0) ? {4'h0, `CMD_LOAD_A} :
                        (load_idx_r == 2'h1) ? {4'h0, `CMD_LOAD_B} : {4'h0, `CMD_LOAD_C};
          load_idx_r <= (load_idx_r == 2'h2) ? 2'h0 : load_idx_r + 2'h1;
          if (load_idx_r == 2'h2)
            host_state_r <= H_WAIT;
        end
        H_PULSE:
          if (cnt_r >= PULSE_CYC - 1)
          begin
            pulse_r      <= 1'b0;
            cnt_r        <= 32'h0;
            host_state_r <= H_WAIT;
          end
          else
            cnt_r <= cnt_r + 32'h1;
        H_WAIT:
          if (cnt_r >= WAIT_CYC - 1)
          begin
            busy_out     <= 1'b0;
            host_state_r <= H_IDLE;
          end
          else
            cnt_r <= cnt_r + 32'h1;
        default:
          host_state_r <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pgo_r           <= 1'b0;
      rd_range_out    <= 12'h000;
      rd_settings_out <= 12'h000;
      pin_fail_out    <= 1'b0;
      pulse_tail_r    <= 2'h0;
    end
    else
    begin
      pgo_r           <= pin_mode_in;
      rd_range_out    <= link.rd_range;
      rd_settings_out <= link.rd_settings;
      // The synchronised pin lags our own pulse by two cycles; the tail masks that lag.
      pulse_tail_r    <= {pulse_tail_r[0], pulse_r};
      pin_fail_out    <= !lvl_r && !pulse_r && (pulse_tail_r == 2'h0);
    end
  end

  assign link.wr_valid    = wr_valid_r;
  assign link.wr_addr     = wr_addr_r;
  assign link.wr_data     = wr_data_r;
  assign link.pgo_low     = pgo_r;
  assign link.host_out_oe = pulse_r;
endmodule

/* File: otp_link_sva.sv */
// Purpose: Watches the link between the host end and the sensor end.
// Assumes: One clock and a synchronous active-high reset.
// Notes:   Wait and pulse counts arrive as parameters from the bench.
`include "otp_defines.svh"
module otp_link_sva #(
  parameter int WAIT_CYC  = 10,
  parameter int PULSE_CYC = 20
) (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        wr_valid,
  input wire logic [7:0]  wr_addr,
  input wire logic [11:0] wr_data,
  input wire logic [11:0] rd_range,
  input wire logic [11:0] rd_settings,
  input wire logic [1:0]  rd_commit_count,
  input wire logic        rd_magnet,
  input wire logic        dev_out_oe,
  input wire logic        dev_out_o,
  input wire logic        host_out_oe
);
  int gap_r;
  int low_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Cycles since the last write, saturating once the guard wait is met.
  always_ff @(posedge clk_in)
  begin
    if (rst_in) gap_r <= WAIT_CYC;
    else if (wr_valid) gap_r <= 0;
    else if (gap_r < WAIT_CYC) gap_r <= gap_r + 1;
  end
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !host_out_oe) low_r <= 0;
    else low_r <= low_r + 1;
  end
  property p_wait;
    wr_valid && !(wr_addr == `CMD_ADDR && (wr_data[7:0] == `CMD_LOAD_B ||
      wr_data[7:0] == `CMD_LOAD_C)) |-> gap_r >= WAIT_CYC - 1;
  endproperty
  a_wait: assert property (p_wait) else $error("write came before the guard wait");
  property p_pulse;
    $fell(host_out_oe) |-> low_r >= PULSE_CYC;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pin low pulse too short");
  property p_reload;
    wr_valid && wr_addr == `CMD_ADDR && wr_data[7:0] == `CMD_LOAD_A |=>
      wr_valid && wr_data[7:0] == `CMD_LOAD_B ##1 wr_valid && wr_data[7:0] == `CMD_LOAD_C;
  endproperty
  a_reload: assert property (p_reload) else $error("reload sequence broken");
  property p_range_wr;
    wr_valid && wr_addr == 8'h00 |=> rd_range == $past(wr_data);
  endproperty
  a_range_wr: assert property (p_range_wr) else $error("range register not written");
  property p_set_wr;
    wr_valid && wr_addr == 8'h01 |=> rd_settings == $past(wr_data);
  endproperty
  a_set_wr: assert property (p_set_wr) else $error("settings register not written");
  property p_count_step;
    $changed(rd_commit_count) |->
      rd_commit_count == $past(rd_commit_count) + 2'h1 && $past(rd_commit_count) != 2'h3;
  endproperty
  a_count_step: assert property (p_count_step) else $error("commit count stepped wrongly");
  property p_no_mag;
    wr_valid && wr_addr == `CMD_ADDR && wr_data[7:0] == `CMD_BURN_ANGLE && !rd_magnet |=>
      not (##[0:40] $changed(rd_commit_count));
  endproperty
  a_no_mag: assert property (p_no_mag) else $error("commit made without magnet");
  property p_fail_hold;
    dev_out_oe && !dev_out_o |=> dev_out_oe && !dev_out_o;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("failure drive released");
  c_burn: cover property (wr_valid && wr_addr == `CMD_ADDR && wr_data[7:0] == `CMD_BURN_ANGLE);
  c_fail: cover property ($rose(dev_out_oe));
  c_pulse: cover property ($fell(host_out_oe));
endmodule

/* File: testbench.sv */
// Purpose: Drives the host user side and the sensor inputs, checks both ends.
// Assumes: Wait and pulse counts shortened to 10 and 20 cycles.
// Notes:   Stored contents clear at each reset, so blank cases follow a reset.
`include "otp_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [11:0] d; logic [11:0] er; logic [11:0] es;} row_t;
  localparam int WAIT_C = 10;
  localparam int PULSE_C = 20;
  logic        clk_in, rst_in, req, pin_mode, magnet, busy, pin_fail;
  logic [1:0]  op;
  logic [7:0]  addr;
  logic [11:0] data, angle, position, rd_range_h, rd_settings_h;
  int          fails, samples_checked;
  row_t        rows [4] = '{'{8'h00, 12'h001, 12'h001, 12'h000},
                            '{8'h01, 12'h5A5, 12'h001, 12'h5A5},
                            '{8'h00, 12'hFFF, 12'hFFF, 12'h5A5},
                            '{8'h00, `RANGE_90_DEG, 12'h400, 12'h5A5}};
  otp_link_if i_otp_link_if ();
  otp_sensor_end #(.PULSE_CYC(PULSE_C)) i_otp_sensor_end (.clk_in(clk_in), .rst_in(rst_in),
    .magnet_detected_in(magnet), .angle_in(angle), .position_out(position),
    .link(i_otp_link_if.dev));
  otp_host_end #(.WAIT_CYC(WAIT_C), .PULSE_CYC(PULSE_C)) i_otp_host_end (.clk_in(clk_in),
    .rst_in(rst_in), .req_in(req), .op_in(op), .addr_in(addr), .data_in(data),
    .pin_mode_in(pin_mode), .busy_out(busy), .rd_range_out(rd_range_h),
    .rd_settings_out(rd_settings_h), .pin_fail_out(pin_fail), .link(i_otp_link_if.host));
  otp_link_sva #(.WAIT_CYC(WAIT_C), .PULSE_CYC(PULSE_C)) i_otp_link_sva (.clk_in(clk_in),
    .rst_in(rst_in), .wr_valid(i_otp_link_if.wr_valid), .wr_addr(i_otp_link_if.wr_addr),
    .wr_data(i_otp_link_if.wr_data), .rd_range(i_otp_link_if.rd_range),
    .rd_settings(i_otp_link_if.rd_settings), .rd_commit_count(i_otp_link_if.rd_commit_count),
    .rd_magnet(i_otp_link_if.rd_magnet), .dev_out_oe(i_otp_link_if.dev_out_oe),
    .dev_out_o(i_otp_link_if.dev_out_o), .host_out_oe(i_otp_link_if.host_out_oe));
  task automatic check(input string name, input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset();
    rst_in = 1'h1;
    repeat (5) @(negedge clk_in);
    rst_in = 1'h0;
    repeat (3) @(negedge clk_in);
  endtask
  // Issues one host operation, then lets the busy guard and any burn finish.
  task automatic op_run(input logic [1:0] o, input logic [7:0] a, input logic [11:0] d);
    int n;
    n = 0;
    op = o;
    addr = a;
    data = d;
    req = 1'h1;
    @(negedge clk_in);
    req = 1'h0;
    while (busy !== 1'h0 && n < 2000)
    begin
      @(negedge clk_in);
      n++;
    end
    repeat (30) @(negedge clk_in);
  endtask
  function automatic logic [11:0] cnt();
    return {10'h000, i_otp_link_if.rd_commit_count};
  endfunction
  initial
  begin
    clk_in = 1'h0;
    forever #25 clk_in = ~clk_in;
  end
  initial
  begin
    repeat (20000) @(posedge clk_in);
    fails++;
    complete_run();
  end
  initial
  begin
    fails = 0;
    samples_checked = 0;
    {rst_in, req, op, addr, data, pin_mode, angle} = '0;
    magnet = 1'h1;
    do_reset();
    check("busy", {11'h000, busy}, 12'h000);
    check("range", i_otp_link_if.rd_range, 12'h000);
    foreach (rows[i])
    begin
      op_run(2'h0, rows[i].a, rows[i].d);
      check("range", i_otp_link_if.rd_range, rows[i].er);
      check("settings", i_otp_link_if.rd_settings, rows[i].es);
    end
    op_run(2'h0, `CMD_ADDR, {4'h0, `CMD_BURN_SET});
    op_run(2'h0, 8'h00, 12'h222);
    op_run(2'h1, 8'h00, 12'h000);
    check("reload range", rd_range_h, 12'h400);
    check("reload settings", rd_settings_h, 12'h5A5);
    op_run(2'h0, 8'h00, 12'h222);
    op_run(2'h0, `CMD_ADDR, {4'h0, `CMD_BURN_SET});
    op_run(2'h1, 8'h00, 12'h000);
    check("second commit range", rd_range_h, 12'h400);
    magnet = 1'h0;
    op_run(2'h0, `CMD_ADDR, {4'h0, `CMD_BURN_ANGLE});
    check("count", cnt(), 12'h000);
    magnet = 1'h1;
    op_run(2'h0, 8'h02, 12'h100);
    op_run(2'h0, 8'h03, 12'h300);
    for (int k = 1; k <= 4; k++)
    begin
      op_run(2'h0, `CMD_ADDR, {4'h0, `CMD_BURN_ANGLE});
      check("count", cnt(), (k > 3) ? 12'h003 : 12'(k));
    end
    do_reset();
    op_run(2'h0, `CMD_ADDR, {4'h0, `CMD_BURN_ANGLE});
    op_run(2'h0, 8'h00, 12'h7FF);
    op_run(2'h0, 8'h01, 12'h0AA);
    op_run(2'h0, `CMD_ADDR, {4'h0, `CMD_BURN_SET});
    op_run(2'h1, 8'h00, 12'h000);
    check("range after count", rd_range_h, 12'h000);
    check("settings after count", rd_settings_h, 12'h0AA);
    angle = 12'h0F0;
    op_run(2'h2, 8'h00, 12'h000);
    op_run(2'h2, 8'h00, 12'h000);
    check("zero without option select", i_otp_link_if.rd_zero, 12'h000);
    check("count without option select", cnt(), 12'h001);
    do_reset();
    pin_mode = 1'h1;
    angle = 12'h200;
    op_run(2'h2, 8'h00, 12'h000);
    check("count", cnt(), 12'h000);
    check("position", position, 12'h200);
    angle = 12'h600;
    op_run(2'h2, 8'h00, 12'h000);
    angle = 12'h650;
    repeat (4) @(negedge clk_in);
    check("position", position, 12'h450);
    check("zero", i_otp_link_if.rd_zero, 12'h200);
    check("stop", i_otp_link_if.rd_stop, 12'h600);
    check("count", cnt(), 12'h001);
    angle = 12'h700;
    op_run(2'h2, 8'h00, 12'h000);
    op_run(2'h2, 8'h00, 12'h000);
    check("zero", i_otp_link_if.rd_zero, 12'h200);
    check("count", cnt(), 12'h001);
    do_reset();
    angle = 12'h100;
    op_run(2'h2, 8'h00, 12'h000);
    magnet = 1'h0;
    op_run(2'h2, 8'h00, 12'h000);
    check("fail", {11'h000, pin_fail}, 12'h001);
    check("pin", {11'h000, i_otp_link_if.out_level}, 12'h000);
    check("position", position, 12'h000);
    check("count", cnt(), 12'h000);
    complete_run();
  end
endmodule
